// ==== bcr_defs.sv ====
// Summary of operation
// - ECC levels two and three log uncorrectable errors and withhold bad data; three logs correctable.
// - Basic ECC level in a one-megabit system formats pages as 64 data bytes.
// - Parity interrupt enable raises an interrupt on host write-data parity errors.
// - DMA enable selects DMA handshaking; cleared means host polling.
// - Normal interrupt enable interrupts the host after each successful command.
// - Start page register sets starting page; module select field is 0000B for one module.
// - Starting page is 11 bits across both bytes, high byte 00000XXX, pages 0-2047.
// - Busy reads 1 while a command runs; bits 1-6 valid only when idle.
// - Operation-complete bit sets when a command finishes successfully.
// - Operation-failed bit sets when a command cannot finish.
// - Timing-error bit sets on formatter timing fault or host falling behind.
// - Correctable-error bit sets for correctable error in last block read.
// - Uncorrectable-error bit sets for uncorrectable error in last block read.
// - Parity checked and flagged only for host-written data, never on reads.
// - FIFO-ready means data or space while busy; idle zero means FIFO empty.
// - Port select low reaches data and parametric registers; high reaches status and commands.
// - Pointer advances after each data-port write and stops at 00H.
// - Status has busy in bit 7, FIFO-ready in bit 0; 40H means success.
// - Data access reaches register chosen by 4-bit pointer, 0000 is FIFO.
// - Control write 0001xxxx issues a command; 0000xxxx loads the pointer.
`default_nettype none

package bcr_pkg;
  // Register pointer targets
  localparam logic [3:0] BCR_PTR_FIFO = 4'h0;
  localparam logic [3:0] BCR_PTR_UTIL = 4'hA;
  localparam logic [3:0] BCR_PTR_BLEN_LO = 4'hB;
  localparam logic [3:0] BCR_PTR_BLEN_HI = 4'hC;
  localparam logic [3:0] BCR_PTR_ENABLE = 4'hD;
  localparam logic [3:0] BCR_PTR_PAGE_LO = 4'hE;
  localparam logic [3:0] BCR_PTR_PAGE_HI = 4'hF;
  localparam logic [3:0] BCR_PTR_RESET = 4'h0;
  // Control port upper nibble codes
  localparam logic [3:0] BCR_CTL_POINTER = 4'h0;
  localparam logic [3:0] BCR_CTL_COMMAND = 4'h1;
  // Feature enable bit positions
  localparam int BCR_EN_NORM_INT = 0;
  localparam int BCR_EN_ERR_INT = 1;
  localparam int BCR_EN_PAR_INT = 2;
  localparam int BCR_EN_BOOT_WR = 3;
  localparam int BCR_EN_RD_BUF = 4;
  localparam int BCR_EN_RCD = 5;
  localparam int BCR_EN_ICD = 6;
  localparam int BCR_EN_DMA = 7;
  // Controller state bit positions
  localparam int BCR_ST_BUSY = 7;
  localparam int BCR_ST_DONE = 6;
  localparam int BCR_ST_FAIL = 5;
  localparam int BCR_ST_TIMING = 4;
  localparam int BCR_ST_CORR = 3;
  localparam int BCR_ST_UNCORR = 2;
  localparam int BCR_ST_PARITY = 1;
  localparam int BCR_ST_FIFO_RDY = 0;
  // Start page high byte layout
  localparam int BCR_PAGE_HI_BITS = 3;
  localparam int BCR_MOD_SEL_LSB = 4;
  // Page sizes in bytes
  localparam logic [6:0] BCR_PAGE_ECC = 7'h40;
  localparam logic [6:0] BCR_PAGE_RAW = 7'h44;
  // Synchroniser width: cs, rd, wr, select, parity, 8 data bits
  localparam int BCR_SYNC_W = 13;
  localparam logic [7:0] BCR_BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {
    BCR_ECC_OFF = 2'b00,
    BCR_ECC_BASIC = 2'b01,
    BCR_ECC_LOG = 2'b10,
    BCR_ECC_FULL = 2'b11
  } bcr_ecc_e;
endpackage : bcr_pkg

// Three-stage pin synchroniser; a change counts once stages two and three agree
module bcr_sync3
  import bcr_pkg::*;
#(
  parameter int W = BCR_SYNC_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pin side and stable side
  input wire logic [W-1:0] pins_in,
  output logic [W-1:0] stable_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } bcr_sync_s;

  bcr_sync_s st;
  bcr_sync_s next_st;
  logic [W-1:0] next_stable;

  // Per-bit agreement filter; a bit moves only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      assign next_stable[gi] = (st.s2[gi] == st.s3[gi]) ? st.s3[gi] : st.stable[gi];
    end
  endgenerate

  // Shift the stages; stage one feeds only stage two
  always_comb begin
    next_st = st;
    next_st.s1 = pins_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.stable = next_stable;
  end

  // Stages reset high so idle strobes do not fire on release
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign stable_out = st.stable;
endmodule : bcr_sync3

`default_nettype wire

// ==== bcr_host_regs.sv ====
`default_nettype none

module bcr_host_regs
  import bcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Host bus pins
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic port_select_line_in,
  input wire logic [7:0] data_in,
  input wire logic data_parity_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic intr_out,
  output logic dma_req_out,
  // Controller core status
  input wire logic busy_in,
  input wire logic op_done_in,
  input wire logic op_fail_in,
  input wire logic timing_err_in,
  input wire logic corr_err_in,
  input wire logic uncorr_err_in,
  input wire logic fifo_ready_in,
  input wire logic fifo_empty_in,
  input wire logic [7:0] fifo_rdata_in,
  // Controller core requests
  output logic cmd_valid_out,
  output logic [3:0] cmd_code_out,
  output logic fifo_wr_out,
  output logic [7:0] fifo_wdata_out,
  output logic fifo_rd_out,
  // Configuration to the core
  output logic [1:0] ecc_level_out,
  output logic [6:0] page_bytes_out,
  output logic withhold_bad_data_out,
  output logic log_uncorr_out,
  output logic log_corr_out,
  output logic dma_mode_out,
  output logic boot_write_en_out,
  output logic read_buffering_mode_out,
  output logic [10:0] start_page_out,
  output logic [3:0] module_sel_out,
  output logic [15:0] block_length_out
);
  typedef struct packed {
    logic [3:0] register_pointer;
    logic [7:0] feature_enable;
    logic [7:0] utility;
    logic [7:0] blen_lo;
    logic [7:0] blen_hi;
    logic [7:0] start_page_low;
    logic [7:0] start_page_high;
    logic [6:1] flags;
    logic [7:0] wr_hold;
    logic par_hold;
    logic sel_hold;
    logic rd_prev;
    logic wr_prev;
    logic [7:0] rdata;
    logic oe;
    logic intr;
    logic dma_req;
    logic cmd_valid;
    logic [3:0] cmd_code;
    logic fifo_wr;
    logic [7:0] fifo_wdata;
    logic fifo_rd;
    bcr_ecc_e ecc;
    logic [6:0] page_bytes;
    logic log_corr;
  } bcr_st_s;

  localparam bcr_st_s ST_RST = '{
    register_pointer: BCR_PTR_RESET,
    ecc: BCR_ECC_OFF,
    page_bytes: BCR_PAGE_RAW,
    default: '0
  };

  bcr_st_s st;
  bcr_st_s next_st;
  logic [BCR_SYNC_W-1:0] pins_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic sel_s;
  logic par_s;
  logic [7:0] dat_s;
  logic rd_act;
  logic wr_act;
  logic rd_start;
  logic wr_end;
  logic ctl_write;
  logic data_write;
  logic stat_read;
  logic par_bad;
  logic [7:0] status_byte;
  logic [7:0] data_read;

  // All host pins share one synchroniser so data and strobes stay aligned
  bcr_sync3 #(
    .W(BCR_SYNC_W)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pins_in({cs_n_in, rd_n_in, wr_n_in, port_select_line_in, data_parity_in, data_in}),
    .stable_out(pins_s)
  );

  // Strobe decoding from synchronised pins
  assign {cs_n_s, rd_n_s, wr_n_s, sel_s, par_s, dat_s} = pins_s;
  assign rd_act = ~cs_n_s & ~rd_n_s;
  assign wr_act = ~cs_n_s & ~wr_n_s;
  assign rd_start = rd_act & ~st.rd_prev;
  assign wr_end = st.wr_prev & ~wr_act;  // Act at strobe end, data settled
  assign ctl_write = wr_end & st.sel_hold;
  assign data_write = wr_end & ~st.sel_hold;
  assign stat_read = rd_start & sel_s;
  assign par_bad = ~(^{st.wr_hold, st.par_hold});  // Odd parity expected

  // Status byte; bits 1-6 meaningful only once busy drops
  always_comb begin
    status_byte = 8'h00;
    status_byte[BCR_ST_BUSY] = busy_in;
    status_byte[BCR_ST_DONE:BCR_ST_PARITY] = st.flags;
    status_byte[BCR_ST_FIFO_RDY] = busy_in ? fifo_ready_in : ~fifo_empty_in;
  end

  // Data port read mux; write-only registers read as zero
  always_comb begin
    data_read = BCR_BYTE_RESET;
    unique case (st.register_pointer)
      BCR_PTR_FIFO: data_read = fifo_rdata_in;
      BCR_PTR_UTIL: data_read = st.utility;
      BCR_PTR_PAGE_LO: data_read = st.start_page_low;
      BCR_PTR_PAGE_HI: data_read = st.start_page_high;
      default: data_read = BCR_BYTE_RESET;
    endcase
  end

  // Next-state logic for the whole port
  always_comb begin
    next_st = st;
    next_st.rd_prev = rd_act;
    next_st.wr_prev = wr_act;
    next_st.cmd_valid = 1'b0;
    next_st.fifo_wr = 1'b0;
    next_st.fifo_rd = 1'b0;
    // Hold the byte and select while the write strobe is low
    if (wr_act) begin
      next_st.wr_hold = dat_s;
      next_st.par_hold = par_s;
      next_st.sel_hold = sel_s;
    end
    // Read drive: data captured at strobe start, released at strobe end
    next_st.oe = rd_act;
    if (rd_start) begin
      next_st.rdata = sel_s ? status_byte : data_read;
      next_st.fifo_rd = ~sel_s && (st.register_pointer == BCR_PTR_FIFO);
    end
    // Control port: command issue or pointer load
    if (ctl_write) begin
      if (st.wr_hold[7:4] == BCR_CTL_COMMAND) begin
        next_st.cmd_valid = 1'b1;
        next_st.cmd_code = st.wr_hold[3:0];
        next_st.flags = '0;  // New command starts with clean results
      end else if (st.wr_hold[7:4] == BCR_CTL_POINTER) begin
        next_st.register_pointer = st.wr_hold[3:0];
      end
    end
    // Data port write to the selected register
    if (data_write) begin
      unique case (st.register_pointer)
        BCR_PTR_FIFO: begin
          next_st.fifo_wr = 1'b1;
          next_st.fifo_wdata = st.wr_hold;
        end
        BCR_PTR_UTIL: next_st.utility = st.wr_hold;
        BCR_PTR_BLEN_LO: next_st.blen_lo = st.wr_hold;
        BCR_PTR_BLEN_HI: next_st.blen_hi = st.wr_hold;
        BCR_PTR_ENABLE: next_st.feature_enable = st.wr_hold;
        BCR_PTR_PAGE_LO: next_st.start_page_low = st.wr_hold;
        BCR_PTR_PAGE_HI: next_st.start_page_high = st.wr_hold;
        default: ;
      endcase
      // Auto-advance; wraps 1111 to 0000 and then parks on the FIFO
      if (st.register_pointer != BCR_PTR_FIFO) begin
        next_st.register_pointer = st.register_pointer + 4'h1;
      end
    end
    // Sticky results; an event in the clearing cycle still lands
    if (op_done_in) next_st.flags[BCR_ST_DONE] = 1'b1;
    if (op_fail_in) next_st.flags[BCR_ST_FAIL] = 1'b1;
    if (timing_err_in) next_st.flags[BCR_ST_TIMING] = 1'b1;
    if (corr_err_in) next_st.flags[BCR_ST_CORR] = 1'b1;
    if (uncorr_err_in) next_st.flags[BCR_ST_UNCORR] = 1'b1;
    // Parity only on bytes the host writes to the data port
    if (data_write && par_bad) begin
      next_st.flags[BCR_ST_PARITY] = 1'b1;
    end
    // Interrupt request; held until status is read, new event wins
    if (stat_read) begin
      next_st.intr = 1'b0;
    end
    if (op_done_in && st.feature_enable[BCR_EN_NORM_INT]) begin
      next_st.intr = 1'b1;
    end
    if (data_write && par_bad && st.feature_enable[BCR_EN_PAR_INT]) begin
      next_st.intr = 1'b1;
    end
    // DMA request only in DMA mode while the FIFO can move a byte
    next_st.dma_req = st.feature_enable[BCR_EN_DMA] & busy_in & fifo_ready_in;
    // Error-correction level and page size follow the enable byte
    unique case ({next_st.feature_enable[BCR_EN_ICD], next_st.feature_enable[BCR_EN_RCD]})
      2'b00: next_st.ecc = BCR_ECC_OFF;
      2'b01: next_st.ecc = BCR_ECC_BASIC;
      default: begin
        next_st.ecc = next_st.feature_enable[BCR_EN_ERR_INT] ? BCR_ECC_FULL : BCR_ECC_LOG;
      end
    endcase
    next_st.page_bytes = (next_st.ecc == BCR_ECC_OFF) ? BCR_PAGE_RAW : BCR_PAGE_ECC;
    next_st.log_corr = (next_st.ecc == BCR_ECC_FULL);
  end

  // Single state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign data_out = st.rdata;
  assign data_oe_out = st.oe;
  assign intr_out = st.intr;
  assign dma_req_out = st.dma_req;
  assign cmd_valid_out = st.cmd_valid;
  assign cmd_code_out = st.cmd_code;
  assign fifo_wr_out = st.fifo_wr;
  assign fifo_wdata_out = st.fifo_wdata;
  assign fifo_rd_out = st.fifo_rd;
  assign ecc_level_out = st.ecc;
  assign page_bytes_out = st.page_bytes;
  assign withhold_bad_data_out = st.ecc[1];
  assign log_uncorr_out = st.ecc[1];
  assign log_corr_out = st.log_corr;
  assign dma_mode_out = st.feature_enable[BCR_EN_DMA];
  assign boot_write_en_out = st.feature_enable[BCR_EN_BOOT_WR];
  assign read_buffering_mode_out = st.feature_enable[BCR_EN_RD_BUF];
  assign start_page_out = {st.start_page_high[BCR_PAGE_HI_BITS-1:0], st.start_page_low};
  assign module_sel_out = st.start_page_high[7:BCR_MOD_SEL_LSB];
  assign block_length_out = {st.blen_hi, st.blen_lo};

  // Checks
  sequence s_ctl_write;
    wr_end && st.sel_hold;
  endsequence

  sequence s_data_write;
    wr_end && !st.sel_hold;
  endsequence

  property p_cmd_issue;
    @(posedge clk_in) disable iff (rst_in)
    s_ctl_write and (st.wr_hold[7:4] == 4'h1) |=> cmd_valid_out && cmd_code_out == $past(st.wr_hold[3:0]);
  endproperty
  a_cmd_issue: assert property (p_cmd_issue) else $error("command not issued");

  property p_ptr_load;
    @(posedge clk_in) disable iff (rst_in)
    s_ctl_write and (st.wr_hold[7:4] == 4'h0) |=> st.register_pointer == $past(st.wr_hold[3:0]);
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_ptr_adv;
    @(posedge clk_in) disable iff (rst_in)
    s_data_write and (st.register_pointer != 4'h0) |=>
      st.register_pointer == 4'($past(st.register_pointer) + 4'h1);
  endproperty
  a_ptr_adv: assert property (p_ptr_adv) else $error("pointer did not advance");

  property p_ptr_stop;
    @(posedge clk_in) disable iff (rst_in)
    s_data_write and (st.register_pointer == 4'h0) |=> st.register_pointer == 4'h0 && fifo_wr_out;
  endproperty
  a_ptr_stop: assert property (p_ptr_stop) else $error("pointer left FIFO");

  property p_page_size;
    @(posedge clk_in) disable iff (rst_in)
    ##1 (page_bytes_out == 7'h40) == ($past(next_st.feature_enable[6:5]) != 2'b00);
  endproperty
  a_page_size: assert property (p_page_size) else $error("page size mismatch");

  property p_busy_bit;
    @(posedge clk_in) disable iff (rst_in)
    rd_start && sel_s |=> data_out[7] == $past(busy_in) ##1 (!data_oe_out || data_out[7] == $past(busy_in, 2));
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("busy bit wrong");

  property p_done_flag;
    @(posedge clk_in) disable iff (rst_in)
    op_done_in |=> st.flags[6] [*1] ##0 (stat_read -> st.flags[6]);
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("complete flag lost");

  property p_parity_source;
    @(posedge clk_in) disable iff (rst_in)
    $rose(st.flags[1]) |-> $past(data_write && par_bad);
  endproperty
  a_parity_source: assert property (p_parity_source) else $error("parity set outside write");

  property p_intr_hold;
    @(posedge clk_in) disable iff (rst_in)
    intr_out && !stat_read |=> intr_out;
  endproperty
  a_intr_hold: assert property (p_intr_hold) else $error("interrupt dropped early");

  property p_idle_ready;
    @(posedge clk_in) disable iff (rst_in)
    rd_start && sel_s && !busy_in |=> data_out[0] == !$past(fifo_empty_in);
  endproperty
  a_idle_ready: assert property (p_idle_ready) else $error("idle FIFO ready wrong");
endmodule : bcr_host_regs

`default_nettype wire

// ==== bcr_host_model.sv ====
`default_nettype none

module bcr_host_model (
  // Clock
  input wire logic clk_in,
  // Host pins toward the device
  output var logic cs_n_out,
  output var logic rd_n_out,
  output var logic wr_n_out,
  output var logic sel_out,
  output var logic [7:0] data_out,
  output var logic par_out,
  // Device read data
  input wire logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: strobes high, data lines parked
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    sel_out = 1'b0;
    data_out = 8'h00;
    par_out = 1'b0;
  end

  // Six cycles each way clears the four-cycle synchroniser minimum
  task automatic bus_wr(input logic sel, input logic [7:0] d, input logic bad);
    @(posedge clk_in);
    #2;
    sel_out = sel;
    data_out = d;
    par_out = ~^d ^ bad;
    cs_n_out = 1'b0;
    wr_n_out = 1'b0;
    repeat (6) @(posedge clk_in);
    #2;
    wr_n_out = 1'b1;
    cs_n_out = 1'b1;
    data_out = ~d; // Released lines must not keep the old value
    repeat (6) @(posedge clk_in);
    #2;
  endtask : bus_wr

  // Read data is taken at the last edge before the strobe rises
  task automatic bus_rd(input logic sel, output logic [7:0] d);
    @(posedge clk_in);
    #2;
    sel_out = sel;
    par_out = ~par_out; // Parity lines are noise on reads
    cs_n_out = 1'b0;
    rd_n_out = 1'b0;
    repeat (6) @(posedge clk_in);
    d = data_in;
    #2;
    rd_n_out = 1'b1;
    cs_n_out = 1'b1;
    repeat (6) @(posedge clk_in);
    #2;
  endtask : bus_rd
endmodule : bcr_host_model

`default_nettype wire

// ==== tb_bcr_host_regs.sv ====
`default_nettype none

module tb_bcr_host_regs
  import bcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] ev = 5'h00;
  logic busy = 1'b0;
  logic rdy = 1'b0;
  logic emp = 1'b1;
  logic oe;
  int oe_cnt = 0;
  logic [7:0] rdata = 8'h00;
  wire logic cs_n, rd_n, wr_n, sel, par;
  wire logic [7:0] hd, dout;
  logic intr, dma_req, cmd_v, fwr, frd, wh, lu, lc, dm, bw, rb;
  logic [3:0] code, modsel, last_code;
  logic [7:0] fwd, mstat, v, blo, plo, phi;
  logic [1:0] ecc;
  logic [6:0] pgb;
  logic [10:0] spage;
  logic [15:0] blen;
  logic [7:0] enq[$];
  int error_cnt = 0;
  int checked = 0;
  int cmd_cnt = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  int n;
  wire logic [15:0] cfgw = {1'b0, ecc, pgb, wh, lu, lc, dm, bw, rb};

  always #12.5 clk_in = ~clk_in;

  bcr_host_model bcr_host_model_inst (.clk_in(clk_in), .cs_n_out(cs_n), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .sel_out(sel), .data_out(hd), .par_out(par), .data_in(dout));

  bcr_host_regs bcr_host_regs_inst (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .port_select_line_in(sel), .data_in(hd),
    .data_parity_in(par), .data_out(dout), .data_oe_out(oe), .intr_out(intr),
    .dma_req_out(dma_req), .busy_in(busy), .op_done_in(ev[0]), .op_fail_in(ev[1]),
    .timing_err_in(ev[2]), .corr_err_in(ev[3]), .uncorr_err_in(ev[4]),
    .fifo_ready_in(rdy), .fifo_empty_in(emp), .fifo_rdata_in(rdata),
    .cmd_valid_out(cmd_v), .cmd_code_out(code), .fifo_wr_out(fwr),
    .fifo_wdata_out(fwd), .fifo_rd_out(frd), .ecc_level_out(ecc),
    .page_bytes_out(pgb), .withhold_bad_data_out(wh), .log_uncorr_out(lu),
    .log_corr_out(lc), .dma_mode_out(dm), .boot_write_en_out(bw),
    .read_buffering_mode_out(rb), .start_page_out(spage), .module_sel_out(modsel),
    .block_length_out(blen));

  // Count one-cycle request pulses and bus drive cycles from the device
  always @(posedge clk_in) begin
    if (cmd_v === 1'b1) begin
      cmd_cnt++;
      last_code = code;
    end
    if (fwr === 1'b1) wr_cnt++;
    if (frd === 1'b1) rd_cnt++;
    if (oe === 1'b1) oe_cnt++;
  end

  // Expected configuration word from an enable byte
  function automatic logic [15:0] cfg(input logic [7:0] e);
    logic [1:0] l;
    l = e[6] ? (e[1] ? 2'd3 : 2'd2) : (e[5] ? 2'd1 : 2'd0);
    return {1'b0, l, (l == 2'd0) ? BCR_PAGE_RAW : BCR_PAGE_ECC, l[1], l[1], l == 2'd3,
      e[7], e[3], e[4]};
  endfunction : cfg

  task automatic chk_rd(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_rd

  task automatic chk_out(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_out

  task automatic ptr(input logic [3:0] p);
    bcr_host_model_inst.bus_wr(1'b1, {BCR_CTL_POINTER, p}, 1'b0);
  endtask : ptr

  task automatic dw(input logic [7:0] d);
    bcr_host_model_inst.bus_wr(1'b0, d, 1'b0);
  endtask : dw

  // Status read; the bus is driven for as long as the strobe was held low
  task automatic stat(input logic [7:0] e);
    int m;
    m = oe_cnt;
    bcr_host_model_inst.bus_rd(1'b1, v);
    chk_rd("status", e, v);
    chk_out("drive cycles", 16'd6, 16'(oe_cnt - m));
  endtask : stat

  // One-cycle core event, then one spare cycle for the flag to land
  task automatic pulse(input int k);
    @(posedge clk_in);
    #2;
    ev = 5'h01 << k;
    @(posedge clk_in);
    #2;
    ev = 5'h00;
    @(posedge clk_in);
    #2;
  endtask : pulse

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Whole run is about a thousand cycles; this bound of 20000 cycles leaves wide margin
  initial begin
    #(25 * 20000);
    error_cnt++;
    $display("mismatch watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    void'($urandom(37));
    repeat (4) @(posedge clk_in);
    #2;
    rst_in = 1'b0;
    chk_out("config", cfg(8'h00), cfgw);
    stat(8'h00);
    $display("test reset done");
    // Parametric load, then pointer parks on the FIFO
    blo = $urandom;
    plo = $urandom;
    phi = $urandom;
    ptr(4'hB);
    enq.delete();
    enq = '{blo, 8'h10, 8'h20, plo, phi};
    foreach (enq[i]) dw(enq[i]);
    chk_out("blen", {8'h10, blo}, blen);
    chk_out("page", {5'h00, phi[2:0], plo}, {5'h00, spage});
    chk_out("module", {12'h000, phi[7:4]}, {12'h000, modsel});
    chk_out("config", cfg(8'h20), cfgw);
    n = wr_cnt;
    dw(8'hC3);
    dw(blo);
    chk_out("fifo writes", 16'(n + 2), 16'(wr_cnt));
    chk_rd("fifo data", blo, fwd);
    ptr(4'hE);
    bcr_host_model_inst.bus_rd(1'b0, v);
    chk_rd("page low", plo, v);
    ptr(4'hF);
    bcr_host_model_inst.bus_rd(1'b0, v);
    chk_rd("page high", phi, v);
    $display("test parametric done");
    // Host values 00 and 20 first, then other levels and random bytes
    enq = '{8'h00, 8'h20, 8'h40, 8'h42, 8'h60, 8'h62};
    repeat (6) enq.push_back(8'($urandom));
    foreach (enq[i]) begin
      ptr(4'hD);
      dw(enq[i]);
      chk_out("config", cfg(enq[i]), cfgw);
    end
    $display("test enable done");
    // Every command code, then an undefined upper nibble
    for (int c = 0; c < 16; c++) begin
      bcr_host_model_inst.bus_wr(1'b1, {BCR_CTL_COMMAND, 4'(c)}, 1'b0);
      chk_out("command", 16'(c), {12'h000, last_code});
    end
    n = cmd_cnt;
    bcr_host_model_inst.bus_wr(1'b1, 8'h23, 1'b0);
    chk_out("command count", 16'(n), 16'(cmd_cnt));
    $display("test command done");
    // Sticky events with normal and parity interrupts enabled
    ptr(4'hD);
    dw(8'h05);
    mstat = 8'h00;
    for (int k = 0; k < 5; k++) begin
      pulse(k);
      mstat = mstat | (8'h40 >> k);
      chk_out("intr", 16'(k == 0), {15'h0000, intr});
      stat(mstat);
      chk_out("intr", 16'h0000, {15'h0000, intr});
    end
    stat(mstat);
    ptr(BCR_PTR_FIFO);
    bcr_host_model_inst.bus_wr(1'b0, 8'h5A, 1'b1);
    mstat = mstat | 8'h02;
    chk_out("intr", 16'h0001, {15'h0000, intr});
    stat(mstat);
    rdata = $urandom;
    n = rd_cnt;
    bcr_host_model_inst.bus_rd(1'b0, v);
    chk_rd("fifo read", rdata, v);
    chk_out("fifo reads", 16'(n + 1), 16'(rd_cnt));
    stat(mstat);
    $display("test events done");
    // Busy and ready levels, flag clear on command, DMA request
    busy = 1'b1;
    rdy = 1'b1;
    stat(mstat | 8'h81);
    bcr_host_model_inst.bus_wr(1'b1, 8'h19, 1'b0);
    stat(8'h81);
    ptr(4'hD);
    dw(8'h80);
    repeat (3) @(posedge clk_in);
    #2;
    chk_out("dma req", 16'h0001, {15'h0000, dma_req});
    rdy = 1'b0;
    repeat (3) @(posedge clk_in);
    #2;
    chk_out("dma req", 16'h0000, {15'h0000, dma_req});
    busy = 1'b0;
    stat(8'h00);
    emp = 1'b0;
    stat(8'h01);
    $display("test busy done");
    // Mid-run reset drops DMA mode and all enables
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #2;
    rst_in = 1'b0;
    chk_out("config", cfg(8'h00), cfgw);
    chk_out("dma req", 16'h0000, {15'h0000, dma_req});
    stat(8'h01);
    $display("test reset again done");
    summarize();
  end
endmodule : tb_bcr_host_regs

`default_nettype wire
